// [verilog/int_xfer_list_list_regs.sv]
// interrupt list registers and descriptor scheduler, controller end
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module int_xfer_list_list_regs #(
   parameter int NUM_BLOCKS = int_xfer_list_sched_pkg::MAP_W
) (
   input wire logic ref_clk,
   input wire logic reset,
   hc_cmd_if.device link,
   input wire logic frameTick,
   input wire logic serviceDone,
   input wire logic serviceAck,
   output logic serviceReq,
   output logic [int_xfer_list_sched_pkg::INDEX_W-1:0] servicedIndex,
   output logic [int_xfer_list_sched_pkg::SIZE_W-1:0] descAddr,
   output logic asyncStart,
   output logic [int_xfer_list_sched_pkg::SIZE_W-1:0] asyncBufferBytes
);
   import int_xfer_list_sched_pkg::*;

   // each map holds one bit per block, so the block count is fixed at the map width
   // and a different value is refused while the design is put together
   if (NUM_BLOCKS != MAP_W) begin : badBlockCount
      $error("NUM_BLOCKS must equal the map width");
   end

   typedef struct packed {
      dev_state_t st;
      logic [CODE_W-1:0] code;
      logic [BLOCK_W-1:0] blockBytes;
      logic [MAP_W-1:0] doneMap;
      logic [MAP_W-1:0] frameDone;
      logic [MAP_W-1:0] skipMap;
      logic [MAP_W-1:0] finalMap;
      logic [SIZE_W-1:0] asyncBytes;
      logic [INDEX_W-1:0] idx;
      logic serviceReq;
      logic [SIZE_W-1:0] descAddr;
      logic asyncStart;
      logic rdValid;
      logic [MAP_W-1:0] rdData;
   } dev_t;

   dev_t s;
   dev_t next_s;
   logic doneRead;
   logic [MAP_W-1:0] ackBit;

   always_comb begin
      next_s = s;
      next_s.asyncStart = 1'b0;
      next_s.rdValid = 1'b0;
      next_s.rdData = MAP_RESET;
      ackBit = MAP_RESET;
      doneRead = 1'b0;

      // code latched first, acted on at data access
      if (link.cmdStrobe) begin
         next_s.code = link.cmdCode;
      end
      if (link.dataStrobe) begin
         case (s.code)
            CMD_RD_BLOCK: begin
               next_s.rdValid = 1'b1;
               next_s.rdData = {22'h00_0000, s.blockBytes};
            end
            // only ten bits stored, rest reads zero
            CMD_WR_BLOCK: next_s.blockBytes = link.wrData[BLOCK_W-1:0];
            // done map and active index reads
            CMD_RD_DONE: begin
               next_s.rdValid = 1'b1;
               next_s.rdData = s.doneMap;
               doneRead = 1'b1;
            end
            CMD_RD_ACTIVE: begin
               next_s.rdValid = 1'b1;
               // index in bits four to zero
               next_s.rdData = {27'h000_0000, s.idx};
            end
            CMD_RD_SKIP: begin
               next_s.rdValid = 1'b1;
               next_s.rdData = s.skipMap;
            end
            CMD_WR_SKIP: next_s.skipMap = link.wrData;
            CMD_RD_FINAL: begin
               next_s.rdValid = 1'b1;
               next_s.rdData = s.finalMap;
            end
            CMD_WR_FINAL: next_s.finalMap = link.wrData;
            CMD_RD_ASYNC: begin
               next_s.rdValid = 1'b1;
               next_s.rdData = {16'h0000, s.asyncBytes};
            end
            CMD_WR_ASYNC: next_s.asyncBytes = link.wrData[SIZE_W-1:0];
            default: begin
               // unknown read codes still answer zero so a driver never hangs
               next_s.rdValid = ~s.code[7];
            end
         endcase
      end

      // bit only for a serviced, acknowledged descriptor
      if (s.st == DEV_WAIT && serviceDone && serviceAck) begin
         ackBit[s.idx] = 1'b1;
      end

      // frame results reach the done map at frame edge
      if (frameTick) begin
         next_s.frameDone = ackBit;
      end else begin
         next_s.frameDone = s.frameDone | ackBit;
      end
      // bits committed by the same edge survive the read
      if (doneRead && frameTick) begin
         next_s.doneMap = s.frameDone;
      end else if (doneRead) begin
         next_s.doneMap = MAP_RESET;
      end else if (frameTick) begin
         next_s.doneMap = s.doneMap | s.frameDone;
      end

      case (s.st)
         DEV_IDLE, DEV_ASYNC: begin
            if (frameTick) begin
               next_s.st = DEV_SCAN;
               next_s.idx = INDEX_RESET;
            end
         end
         DEV_SCAN: begin
            // skip bit set passes the block over
            if (s.skipMap[s.idx]) begin
               // final block ends the list even when skipped
               if (s.finalMap[s.idx] || s.idx == INDEX_LAST) begin
                  next_s.st = DEV_ASYNC;
                  next_s.asyncStart = 1'b1;
               end else begin
                  next_s.idx = s.idx + 5'h01;
               end
            end else begin
               next_s.st = DEV_WAIT;
               next_s.serviceReq = 1'b1;
               // bit n maps to block n, offset n blocks
               next_s.descAddr = SIZE_W'({11'h000, s.idx} * {6'h00, s.blockBytes});
            end
         end
         DEV_WAIT: begin
            if (serviceDone) begin
               next_s.serviceReq = 1'b0;
               // move to the async list after the final one
               if (s.finalMap[s.idx] || s.idx == INDEX_LAST) begin
                  next_s.st = DEV_ASYNC;
                  next_s.asyncStart = 1'b1;
               end else begin
                  next_s.st = DEV_SCAN;
                  next_s.idx = s.idx + 5'h01;
               end
            end
         end
         default: next_s.st = DEV_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s.st <= DEV_IDLE;
         s.code <= 8'h00;
         // block size resets to 64 bytes
         s.blockBytes <= BLOCK_BYTES_RESET;
         s.doneMap <= MAP_RESET;
         s.frameDone <= MAP_RESET;
         s.skipMap <= MAP_RESET;
         s.finalMap <= MAP_RESET;
         s.asyncBytes <= ASYNC_BYTES_RESET;
         s.idx <= INDEX_RESET;
         s.serviceReq <= 1'b0;
         s.descAddr <= 16'h0000;
         s.asyncStart <= 1'b0;
         s.rdValid <= 1'b0;
         s.rdData <= MAP_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign link.rdValid = s.rdValid;
   assign link.rdData = s.rdData;
   assign serviceReq = s.serviceReq;
   assign servicedIndex = s.idx;
   assign descAddr = s.descAddr;
   assign asyncStart = s.asyncStart;
   assign asyncBufferBytes = s.asyncBytes;
endmodule

// [verilog/int_xfer_list_sched_pkg.sv]
// constants and types shared by the interrupt list register ends
package int_xfer_list_sched_pkg;
   localparam int MAP_W = 32;
   localparam int INDEX_W = 5;
   localparam int BLOCK_W = 10;
   localparam int SIZE_W = 16;
   localparam int CODE_W = 8;

   localparam logic [7:0] CMD_RD_BLOCK = 8'h53;
   localparam logic [7:0] CMD_WR_BLOCK = 8'hD3;
   localparam logic [7:0] CMD_RD_DONE = 8'h17;
   localparam logic [7:0] CMD_RD_SKIP = 8'h18;
   localparam logic [7:0] CMD_WR_SKIP = 8'h98;
   localparam logic [7:0] CMD_RD_FINAL = 8'h19;
   localparam logic [7:0] CMD_WR_FINAL = 8'h99;
   localparam logic [7:0] CMD_RD_ACTIVE = 8'h1A;
   localparam logic [7:0] CMD_RD_ASYNC = 8'h34;
   localparam logic [7:0] CMD_WR_ASYNC = 8'hB4;

   localparam logic [9:0] BLOCK_BYTES_RESET = 10'h040;
   localparam logic [31:0] BLOCK_BYTES_MAX = 32'h0000_0400;
   localparam logic [31:0] BLOCK_ALIGN_MASK = 32'h0000_0007;
   localparam logic [15:0] ASYNC_BYTES_RESET = 16'h0200;
   localparam logic [31:0] ASYNC_BYTES_MAX = 32'h0000_1000;
   localparam logic [31:0] MAP_RESET = 32'h0000_0000;
   localparam logic [4:0] INDEX_RESET = 5'h00;
   localparam logic [4:0] INDEX_LAST = 5'h1F;

   // host-side register offsets on the software port
   localparam logic [1:0] HOST_CMD_OFS = 2'h0;
   localparam logic [1:0] HOST_WDATA_OFS = 2'h1;
   localparam logic [1:0] HOST_RDATA_OFS = 2'h2;
   localparam logic [1:0] HOST_STATUS_OFS = 2'h3;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ANSWER_BIT = 1;
   localparam int STAT_REFUSED_BIT = 2;

   typedef enum logic [1:0] {
      DEV_IDLE = 2'b00,
      DEV_SCAN = 2'b01,
      DEV_WAIT = 2'b10,
      DEV_ASYNC = 2'b11
   } dev_state_t;

   typedef enum logic [1:0] {
      HOST_IDLE = 2'b00,
      HOST_CMD = 2'b01,
      HOST_DATA = 2'b10,
      HOST_WAITRD = 2'b11
   } host_state_t;
endpackage

// [verilog/hc_cmd_if.sv]
// command port joining the driver end to the list register end
`timescale 1ns/1ns
interface hc_cmd_if;
   logic cmdStrobe;
   logic [7:0] cmdCode;
   logic dataStrobe;
   logic [31:0] wrData;
   logic rdValid;
   logic [31:0] rdData;

   modport device (
      input cmdStrobe,
      input cmdCode,
      input dataStrobe,
      input wrData,
      output rdValid,
      output rdData
   );
   modport host (
      output cmdStrobe,
      output cmdCode,
      output dataStrobe,
      output wrData,
      input rdValid,
      input rdData
   );
endinterface

// [verilog/int_xfer_list_driver_port.sv]
// driver end: software port turned into command and data accesses
`timescale 1ns/1ns
module int_xfer_list_driver_port (
   input wire logic ref_clk,
   input wire logic reset,
   hc_cmd_if.host link,
   input wire logic [1:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output logic [31:0] rdData
);
   import int_xfer_list_sched_pkg::*;

   typedef struct packed {
      host_state_t st;
      logic [CODE_W-1:0] code;
      logic [31:0] wdata;
      logic [31:0] answer;
      logic answerReady;
      logic refused;
      logic cmdStrobe;
      logic dataStrobe;
      logic [31:0] rdData;
   } host_t;

   host_t s;
   host_t next_s;
   logic known;
   logic isRead;
   logic badValue;

   always_comb begin
      next_s = s;
      next_s.cmdStrobe = 1'b0;
      next_s.dataStrobe = 1'b0;
      next_s.rdData = 32'h0000_0000;
      known = 1'b0;
      badValue = 1'b0;
      isRead = ~wrData[7];
      case (wrData[7:0])
         CMD_RD_BLOCK, CMD_RD_DONE, CMD_RD_SKIP, CMD_RD_FINAL, CMD_RD_ACTIVE,
         CMD_RD_ASYNC, CMD_WR_SKIP, CMD_WR_FINAL: known = 1'b1;
         // block size must be whole eights within range
         CMD_WR_BLOCK: begin
            known = 1'b1;
            badValue = (s.wdata & BLOCK_ALIGN_MASK) != 32'h0000_0000 ||
                       s.wdata >= BLOCK_BYTES_MAX;
         end
         CMD_WR_ASYNC: begin
            known = 1'b1;
            badValue = s.wdata > ASYNC_BYTES_MAX;
         end
         // done map and index have no write code
         default: known = 1'b0;
      endcase

      if (rdStrobe) begin
         case (addr)
            HOST_CMD_OFS: next_s.rdData = {24'h00_0000, s.code};
            HOST_WDATA_OFS: next_s.rdData = s.wdata;
            HOST_RDATA_OFS: next_s.rdData = s.answer;
            default: next_s.rdData = {29'h0000_0000, s.refused, s.answerReady,
                                      s.st != HOST_IDLE};
         endcase
         if (addr == HOST_RDATA_OFS) begin
            next_s.answerReady = 1'b0;
         end
      end

      if (wrStrobe && addr == HOST_WDATA_OFS && s.st == HOST_IDLE) begin
         next_s.wdata = wrData;
      end
      if (wrStrobe && addr == HOST_CMD_OFS) begin
         if (s.st != HOST_IDLE || !known || badValue) begin
            next_s.refused = 1'b1;
         end else begin
            next_s.refused = 1'b0;
            next_s.code = wrData[7:0];
            next_s.st = HOST_CMD;
            next_s.cmdStrobe = 1'b1;
            if (isRead) begin
               next_s.answerReady = 1'b0;
            end
         end
      end

      case (s.st)
         HOST_IDLE: ;
         // code goes out first, data access follows
         HOST_CMD: begin
            next_s.st = HOST_DATA;
            next_s.dataStrobe = 1'b1;
         end
         HOST_DATA: next_s.st = s.code[7] ? HOST_IDLE : HOST_WAITRD;
         HOST_WAITRD: begin
            if (link.rdValid) begin
               next_s.answer = link.rdData;
               next_s.st = HOST_IDLE;
               next_s.answerReady = 1'b1;
            end
         end
         default: next_s.st = HOST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s.st <= HOST_IDLE;
         s.code <= 8'h00;
         s.wdata <= 32'h0000_0000;
         s.answer <= 32'h0000_0000;
         s.answerReady <= 1'b0;
         s.refused <= 1'b0;
         s.cmdStrobe <= 1'b0;
         s.dataStrobe <= 1'b0;
         s.rdData <= 32'h0000_0000;
      end else begin
         s <= next_s;
      end
   end

   assign link.cmdStrobe = s.cmdStrobe;
   assign link.cmdCode = s.code;
   assign link.dataStrobe = s.dataStrobe;
   assign link.wrData = s.wdata;
   assign rdData = s.rdData;
endmodule

// [verification/int_xfer_list_sched_chk.sv]
// checker for the command link between the driver end and the list register end
`timescale 1ns/1ns
module int_xfer_list_sched_chk (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic cmdStrobe,
   input wire logic [7:0] cmdCode,
   input wire logic dataStrobe,
   input wire logic [31:0] wrData,
   input wire logic rdValid,
   input wire logic [31:0] rdData
);
   import int_xfer_list_sched_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   sequence readAccess;
      dataStrobe && !cmdCode[7];
   endsequence
   sequence answerOf(logic [7:0] code);
      rdValid && $past(cmdCode) == code;
   endsequence
   AST_CMD_THEN_DATA: assert property (cmdStrobe |=> dataStrobe)
      else $error("data access did not follow command");
   AST_NOT_BOTH: assert property (!(cmdStrobe && dataStrobe))
      else $error("command and data strobes together");
   AST_CODE_HOLDS: assert property (cmdStrobe |=> $stable(cmdCode))
      else $error("code changed before its data access");
   AST_READ_ANSWER: assert property (readAccess |=> rdValid)
      else $error("read code gave no answer");
   AST_WRITE_SILENT: assert property (dataStrobe && cmdCode[7] |=> !rdValid)
      else $error("write code gave an answer");
   AST_NO_STRAY_ANSWER: assert property (rdValid |->
      $past(dataStrobe) && !$past(cmdCode[7]))
      else $error("answer without a read access");
   AST_IDLE_DATA_ZERO: assert property (!rdValid |-> rdData == 32'h0000_0000)
      else $error("read data not zero outside an answer");
   AST_BLOCK_UPPER_ZERO: assert property (answerOf(CMD_RD_BLOCK) |-> rdData[31:10] == '0)
      else $error("reserved block size bits set");
   AST_INDEX_UPPER_ZERO: assert property (answerOf(CMD_RD_ACTIVE) |-> rdData[31:5] == '0)
      else $error("reserved index bits set");
   AST_ASYNC_UPPER_ZERO: assert property (answerOf(CMD_RD_ASYNC) |-> rdData[31:16] == '0)
      else $error("async size wider than sixteen bits");
endmodule

// [verification/tb.sv]
// self-checking bench for the driver end and list register end pair
`timescale 1ns/1ns
module tb;
   import int_xfer_list_sched_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [31:0] wrData = 32'h0000_0000;
   logic wrStrobe = 1'b0;
   logic rdStrobe = 1'b0;
   logic [31:0] rdData;
   logic frameTick = 1'b0;
   logic serviceDone = 1'b0;
   logic serviceAck = 1'b0;
   logic serviceReq;
   logic [4:0] servicedIndex;
   logic [15:0] descAddr;
   logic asyncStart;
   logic [15:0] asyncBufferBytes;
   int failures = 0;
   int n_compared = 0;
   int asyncCount = 0;
   logic [31:0] rdWord;
   localparam logic [15:0] BS = 16'h03F8;
   hc_cmd_if link();
   int_xfer_list_list_regs int_xfer_list_list_regs_inst (.ref_clk(ref_clk), .reset(reset), .link(link.device),
      .frameTick(frameTick), .serviceDone(serviceDone), .serviceAck(serviceAck),
      .serviceReq(serviceReq), .servicedIndex(servicedIndex), .descAddr(descAddr),
      .asyncStart(asyncStart), .asyncBufferBytes(asyncBufferBytes));
   int_xfer_list_driver_port int_xfer_list_driver_port_inst (.ref_clk(ref_clk), .reset(reset), .link(link.host),
      .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData));
   int_xfer_list_sched_chk int_xfer_list_sched_chk_inst (.ref_clk(ref_clk), .reset(reset),
      .cmdStrobe(link.cmdStrobe), .cmdCode(link.cmdCode), .dataStrobe(link.dataStrobe),
      .wrData(link.wrData), .rdValid(link.rdValid), .rdData(link.rdData));
   always #5 ref_clk = ~ref_clk;
   // the pulse is only one cycle wide, so it is counted where it stands
   always @(posedge ref_clk) begin
      if (asyncStart === 1'b1) begin
         asyncCount++;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge ref_clk);
      wrStrobe <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge ref_clk);
      rdStrobe <= 1'b0;
      #1 d = rdData;
   endtask
   task automatic waitStat(input int b, input logic val);
      logic [31:0] s;
      for (int i = 0; i < 30; i++) begin
         rd(HOST_STATUS_OFS, s);
         if (s[b] === val) break;
      end
      chk({31'h0, s[b]}, {31'h0, val});
   endtask
   task automatic regWr(input logic [7:0] code, input logic [31:0] d);
      wr(HOST_WDATA_OFS, d);
      wr(HOST_CMD_OFS, {24'h0, code});
      waitStat(STAT_BUSY_BIT, 1'b0);
   endtask
   task automatic expectRd(input logic [7:0] code, input logic [31:0] exp);
      logic [31:0] d;
      wr(HOST_CMD_OFS, {24'h0, code});
      waitStat(STAT_ANSWER_BIT, 1'b1);
      rd(HOST_RDATA_OFS, d);
      chk(d, exp);
   endtask
   task automatic refuse(input logic [7:0] code, input logic [31:0] d);
      regWr(code, d);
      waitStat(STAT_REFUSED_BIT, 1'b1);
   endtask
   task automatic pulse();
      @(posedge ref_clk);
      frameTick <= 1'b1;
      @(posedge ref_clk);
      frameTick <= 1'b0;
   endtask
   // serviceReq stays up until the cycle after serviceDone, hence the trailing wait
   task automatic serve(input logic [4:0] idx, input logic ack);
      int i;
      i = 0;
      #1;
      while (serviceReq !== 1'b1 && i < 200) begin
         @(posedge ref_clk);
         #1 i++;
      end
      chk({31'h0, serviceReq}, 32'h0000_0001);
      chk({27'h0, servicedIndex}, {27'h0, idx});
      chk({16'h0, descAddr}, {16'h0, 16'(idx * BS)});
      @(posedge ref_clk);
      serviceDone <= 1'b1;
      serviceAck <= ack;
      @(posedge ref_clk);
      serviceDone <= 1'b0;
      serviceAck <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      expectRd(CMD_RD_BLOCK, 32'h0000_0040);
      expectRd(CMD_RD_ASYNC, 32'h0000_0200);
      chk({16'h0, asyncBufferBytes}, 32'h0000_0200);
      expectRd(CMD_RD_DONE, MAP_RESET);
      expectRd(CMD_RD_SKIP, MAP_RESET);
      expectRd(CMD_RD_FINAL, MAP_RESET);
      expectRd(CMD_RD_ACTIVE, 32'h0000_0000);
      $display("test reset values done");
      regWr(CMD_WR_BLOCK, {22'h0, BS[9:0]});
      expectRd(CMD_RD_BLOCK, {22'h0, BS[9:0]});
      refuse(CMD_WR_BLOCK, 32'h0000_0400);
      refuse(CMD_WR_BLOCK, 32'h0000_0044);
      refuse(8'h97, 32'h0000_0001);
      expectRd(CMD_RD_BLOCK, {22'h0, BS[9:0]});
      regWr(CMD_WR_ASYNC, 32'h0000_1000);
      expectRd(CMD_RD_ASYNC, 32'h0000_1000);
      chk({16'h0, asyncBufferBytes}, 32'h0000_1000);
      regWr(CMD_WR_SKIP, 32'hFFFF_FFF5);
      expectRd(CMD_RD_SKIP, 32'hFFFF_FFF5);
      regWr(CMD_WR_FINAL, 32'h0000_0008);
      expectRd(CMD_RD_FINAL, 32'h0000_0008);
      $display("test register access done");
      pulse();
      serve(5'd1, 1'b1);
      serve(5'd3, 1'b0);
      repeat (4) @(posedge ref_clk);
      chk(32'(asyncCount), 32'h0000_0001);
      expectRd(CMD_RD_DONE, MAP_RESET);
      pulse();
      expectRd(CMD_RD_ACTIVE, 32'h0000_0001);
      expectRd(CMD_RD_DONE, 32'h0000_0002);
      expectRd(CMD_RD_DONE, MAP_RESET);
      serve(5'd1, 1'b0);
      serve(5'd3, 1'b0);
      expectRd(CMD_RD_ACTIVE, 32'h0000_0003);
      // block zero holds a descriptor, so its skip bit may be cleared
      regWr(CMD_WR_SKIP, 32'hFFFF_FFF4);
      pulse();
      serve(5'd0, 1'b1);
      serve(5'd1, 1'b0);
      serve(5'd3, 1'b0);
      repeat (4) @(posedge ref_clk);
      chk(32'(asyncCount), 32'h0000_0003);
      pulse();
      expectRd(CMD_RD_DONE, 32'h0000_0001);
      $display("test scheduler done");
      serve(5'd0, 1'b1);
      serve(5'd1, 1'b1);
      serve(5'd3, 1'b0);
      chk(32'(asyncCount), 32'h0000_0004);
      // the frame edge lands on the edge that executes the clearing read
      wr(HOST_CMD_OFS, {24'h0, CMD_RD_DONE});
      pulse();
      waitStat(STAT_ANSWER_BIT, 1'b1);
      rd(HOST_RDATA_OFS, rdWord);
      chk(rdWord, MAP_RESET);
      expectRd(CMD_RD_DONE, 32'h0000_0003);
      $display("test read against frame edge done");
      report_and_stop();
   end
endmodule
